// ==== scan_range_params.svh ====
// Offsets, field positions, reset values and timings in ns of the range monitor
`ifndef SCAN_RANGE_PARAMS_SVH
`define SCAN_RANGE_PARAMS_SVH

// ====================================================================
// Timing
`define CLK_PERIOD_NS      4
`define BASE_PERIOD_NS     1000000
`define EVENT_EXTRA_NS     150000

// ====================================================================
// Register offsets
`define REG_CTRL           8'h00
`define REG_SELFCAL        8'h04
`define REG_IRQ_STAT       8'h08
`define REG_IRQ_MASK       8'h0c
`define REG_CH_BASE        8'h10
`define REG_CH_STRIDE      8'h10
`define REG_CH_CFG         8'h00
`define REG_CH_LOW_OFF     8'h04
`define REG_CH_UP_OFF      8'h08
`define REG_CH_ALIGN       8'h0c
`define REG_MEAS_BASE      8'h50
`define REG_FLAG_BASE      8'h60

// ====================================================================
// Fields
`define CTRL_SCAN_EN_BIT   0
`define CTRL_EVT_LSB       4
`define CFG_SUP_BIT        4
`define IRQ_DONE_BIT       4
`define REF_CHAN           3'h4

// ====================================================================
// Scale and reset values
`define NORM_MAX           18'sh02710
`define NORM_MIN_BIP       18'sh3d8f0
`define NORM_SPAN          18'sh02710
`define REF_EXPECT         18'sh01388
`define LOW_OFF_RST        16'hfb1e
`define UP_OFF_RST         16'h04e2

`endif

// ==== scan_types_pkg.sv ====
// Types shared by the range monitor modules
package scan_types_pkg;

    typedef enum logic [2:0] {
        RANGE_BIP_10V = 3'h0,
        RANGE_0_10V   = 3'h1,
        RANGE_0_5V    = 3'h2,
        RANGE_1_5V    = 3'h3,
        RANGE_0_20MA  = 3'h4,
        RANGE_4_20MA  = 3'h5
    } range_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CONV = 2'h1,
        ST_WAIT = 2'h2,
        ST_NEXT = 2'h3
    } scan_state_t;

    typedef struct packed {
        logic        [15:0] meas;
        logic               lo_tol;
        logic               up_tol;
        logic               fault;
        logic               under;
        logic               over;
    } class_res_t;

    typedef struct packed {
        logic signed [17:0] value;
        logic signed [17:0] vmin;
        logic signed [17:0] vmax;
        logic signed [17:0] lo_off;
        logic signed [17:0] up_off;
        logic               sup_en;
    } class_req_t;

endpackage : scan_types_pkg

// ==== scan_period_timer.sv ====
// Scan period divider: one tick per acquisition cycle
`timescale 1ns/1ns
module scan_period_timer
    import scan_types_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        enable,
    input  wire logic [19:0] period_cyc,
    output logic             tick
);
    logic [19:0] cnt_q;

    // Counts period_cyc cycles per tick
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !enable) begin
            cnt_q <= 20'h00000;
            tick  <= 1'b0;
        end else if (cnt_q >= period_cyc - 20'h00001) begin
            cnt_q <= 20'h00000;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 20'h00001;
            tick  <= 1'b0;
        end
    end
endmodule : scan_period_timer

// ==== range_classifier.sv ====
// Area classification and clamping of one corrected measurement
`timescale 1ns/1ns
module range_classifier
    import scan_types_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       req_valid,
    input  class_req_t      req,
    output logic            res_valid,
    output class_res_t      res
);
    logic signed [17:0] up_thr;
    logic signed [17:0] lo_thr;

    assign up_thr = req.vmax + req.up_off;
    assign lo_thr = req.vmin + req.lo_off;

    // Five areas, clamp past thresholds
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            res_valid <= 1'b0;
            res       <= '0;
        end else begin
            res_valid <= req_valid;
            if (req_valid) begin
                res.lo_tol <= req.value < req.vmin && req.value >= lo_thr;
                res.up_tol <= req.value > req.vmax && req.value <= up_thr;
                res.under  <= req.sup_en && req.value < lo_thr;
                res.over   <= req.sup_en && req.value > up_thr;
                res.fault  <= req.sup_en && (req.value < lo_thr || req.value > up_thr);
                if (req.value > up_thr) begin
                    res.meas <= up_thr[15:0];
                end else if (req.value < lo_thr) begin
                    res.meas <= lo_thr[15:0];
                end else begin
                    res.meas <= req.value[15:0];
                end
            end
        end
    end

    a_clamp_upper: assert property (@(posedge ref_clk) disable iff (sys_rst)
        req_valid && req.value > up_thr |=> res.meas == $past(up_thr[15:0]))
        else $error("Overflow value not clamped");
    a_fault_gated: assert property (@(posedge ref_clk) disable iff (sys_rst)
        req_valid && !req.sup_en |=> !res.fault && !res.under && !res.over)
        else $error("Fault flags set without supervision");
endmodule : range_classifier

// ==== range_monitor.sv ====
// Four channel scan sequencer, calibration and range monitor top
`timescale 1ns/1ns
`include "scan_range_params.svh"
module range_monitor
    import scan_types_pkg::*;
#(
    parameter logic [19:0] BASE_CYC  = 20'(`BASE_PERIOD_NS / `CLK_PERIOD_NS),
    parameter logic [19:0] EXTRA_CYC = 20'(`EVENT_EXTRA_NS / `CLK_PERIOD_NS)
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [31:0] rdata,
    output logic             conv_start,
    output logic      [2:0]  conv_chan,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_data,
    output logic      [3:0]  lower_tolerance_flag,
    output logic      [3:0]  upper_tolerance_flag,
    output logic      [3:0]  range_fault_flag,
    output logic      [3:0]  underflow_indicator,
    output logic      [3:0]  overflow_indicator,
    output logic      [3:0]  channel_fault_flag,
    output logic             irq
);
    // ================================================================
    // Helpers
    function automatic logic signed [17:0] clamp_off(input logic [15:0] v,
                                                     input logic       upper);
        logic signed [17:0] s;
        logic signed [17:0] lim;
        s   = 18'(signed'(v));
        lim = `NORM_SPAN >>> 2;
        if (upper) begin
            clamp_off = (s < 18'sh0) ? 18'sh0 : ((s > lim) ? lim : s);
        end else begin
            clamp_off = (s > 18'sh0) ? 18'sh0 : ((s < -lim) ? -lim : s);
        end
    endfunction : clamp_off

    function automatic logic signed [17:0] range_min(input range_t r);
        range_min = (r == RANGE_BIP_10V) ? `NORM_MIN_BIP : 18'sh0;
    endfunction : range_min

    // ================================================================
    // Registers
    logic               scan_en_q;
    logic [3:0]         evt_en_q;
    range_t             range_q [4];
    logic [3:0]         sup_en_q;
    logic signed [17:0] lo_off_q [4];
    logic signed [17:0] up_off_q [4];
    logic signed [15:0] align_q [4];
    logic signed [17:0] selfcal_q;
    logic [15:0]        meas_q [4];
    logic [4:0]         irq_stat_q;
    logic [4:0]         irq_mask_q;
    logic [4:0]         irq_set;
    logic               wr_ctrl;
    logic [1:0]         ch_sel;
    logic               ch_hit;
    logic               meas_hit;
    logic               flag_hit;

    assign ch_sel   = addr[5:4] - 2'h1;
    assign ch_hit   = addr >= `REG_CH_BASE && addr < `REG_MEAS_BASE;
    assign meas_hit = addr[7:4] == `REG_MEAS_BASE >> 4;
    assign flag_hit = addr[7:4] == `REG_FLAG_BASE >> 4;
    assign wr_ctrl  = wr_stb && addr == `REG_CTRL;

    // Global control
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            scan_en_q <= 1'b0;
            evt_en_q  <= 4'h0;
        end else if (wr_ctrl) begin
            scan_en_q <= wdata[`CTRL_SCAN_EN_BIT];
            evt_en_q  <= wdata[`CTRL_EVT_LSB +: 4];
        end
    end

    // Per channel configuration, offsets held inside their limits
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 4; i++) begin
                range_q[i]  <= RANGE_BIP_10V;
                sup_en_q[i] <= 1'b0;
                lo_off_q[i] <= 18'(signed'(16'(`LOW_OFF_RST)));
                up_off_q[i] <= 18'(signed'(16'(`UP_OFF_RST)));
                align_q[i]  <= 16'sh0;
            end
        end else if (wr_stb && ch_hit) begin
            case (addr[3:0])
                `REG_CH_CFG: begin
                    range_q[ch_sel]  <= (wdata[2:0] > 3'h5) ? RANGE_BIP_10V
                                                            : range_t'(wdata[2:0]);
                    sup_en_q[ch_sel] <= wdata[`CFG_SUP_BIT];
                end
                `REG_CH_LOW_OFF: lo_off_q[ch_sel] <= clamp_off(wdata[15:0], 1'b0);
                `REG_CH_UP_OFF:  up_off_q[ch_sel] <= clamp_off(wdata[15:0], 1'b1);
                `REG_CH_ALIGN:   align_q[ch_sel]  <= signed'(wdata[15:0]);
                default: ;
            endcase
        end
    end

    // ================================================================
    // Scan period
    logic [19:0] period_cyc;
    logic        tick;

    assign period_cyc = BASE_CYC + EXTRA_CYC * 20'($countones(evt_en_q));

    scan_period_timer u_timer (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .enable     (scan_en_q),
        .period_cyc (period_cyc),
        .tick       (tick)
    );

    // ================================================================
    // Scan sequencer
    scan_state_t state_q;
    logic        pend_q;
    logic [2:0]  chan_q;
    logic        req_valid_q;
    class_req_t  req_q;
    logic        res_valid;
    class_res_t  res;
    logic [1:0]  res_ch_q;
    logic signed [17:0] corr;

    assign corr = 18'(signed'(conv_data)) + 18'(align_q[chan_q[1:0]]) + selfcal_q;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q     <= ST_IDLE;
            pend_q      <= 1'b0;
            chan_q      <= 3'h0;
            conv_start  <= 1'b0;
            conv_chan   <= 3'h0;
            req_valid_q <= 1'b0;
            req_q       <= '0;
            res_ch_q    <= 2'h0;
            selfcal_q   <= 18'sh0;
        end else begin
            conv_start  <= 1'b0;
            req_valid_q <= 1'b0;
            if (tick) begin
                pend_q <= 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    if (tick || pend_q) begin
                        pend_q  <= 1'b0;
                        chan_q  <= 3'h0;
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    conv_start <= 1'b1;
                    conv_chan  <= chan_q;
                    state_q    <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (conv_done) begin
                        if (chan_q == `REF_CHAN) begin
                            selfcal_q <= `REF_EXPECT - 18'(signed'(conv_data));
                        end else begin
                            req_valid_q  <= 1'b1;
                            res_ch_q     <= chan_q[1:0];
                            req_q.value  <= corr;
                            req_q.vmin   <= range_min(range_q[chan_q[1:0]]);
                            req_q.vmax   <= `NORM_MAX;
                            req_q.lo_off <= lo_off_q[chan_q[1:0]];
                            req_q.up_off <= up_off_q[chan_q[1:0]];
                            req_q.sup_en <= sup_en_q[chan_q[1:0]];
                        end
                        state_q <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    if (chan_q == `REF_CHAN) begin
                        state_q <= ST_IDLE;
                    end else begin
                        chan_q  <= chan_q + 3'h1;
                        state_q <= ST_CONV;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    range_classifier u_class (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .req_valid (req_valid_q),
        .req       (req_q),
        .res_valid (res_valid),
        .res       (res)
    );

    // ================================================================
    // Status per channel, refreshed on every conversion of channels 0 to 3
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lower_tolerance_flag <= 4'h0;
            upper_tolerance_flag <= 4'h0;
            range_fault_flag     <= 4'h0;
            underflow_indicator  <= 4'h0;
            overflow_indicator   <= 4'h0;
            channel_fault_flag   <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                meas_q[i] <= 16'h0000;
            end
        end else if (res_valid) begin
            lower_tolerance_flag[res_ch_q] <= res.lo_tol;
            upper_tolerance_flag[res_ch_q] <= res.up_tol;
            range_fault_flag[res_ch_q]     <= res.fault;
            underflow_indicator[res_ch_q]  <= res.under;
            overflow_indicator[res_ch_q]   <= res.over;
            channel_fault_flag[res_ch_q]   <= res.fault;
            meas_q[res_ch_q]               <= res.meas;
        end
    end

    // ================================================================
    // Interrupts: fault onset per channel, scan complete
    always_comb begin
        irq_set = 5'h00;
        if (res_valid && res.fault && !range_fault_flag[res_ch_q]) begin
            irq_set[res_ch_q] = 1'b1;
        end
        irq_set[`IRQ_DONE_BIT] = state_q == ST_NEXT && chan_q == `REF_CHAN;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_stat_q <= 5'h00;
            irq_mask_q <= 5'h00;
            irq        <= 1'b0;
        end else begin
            if (wr_stb && addr == `REG_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~wdata[4:0]) | irq_set;
            end else begin
                irq_stat_q <= irq_stat_q | irq_set;
            end
            if (wr_stb && addr == `REG_IRQ_MASK) begin
                irq_mask_q <= wdata[4:0];
            end
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ================================================================
    // Read port
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata <= 32'h00000000;
        end else if (rd_stb) begin
            rdata <= 32'h00000000;
            if (addr == `REG_CTRL) begin
                rdata <= {24'h000000, evt_en_q, 3'h0, scan_en_q};
            end else if (addr == `REG_SELFCAL) begin
                rdata <= {14'h0000, selfcal_q};
            end else if (addr == `REG_IRQ_STAT) begin
                rdata <= {27'h0000000, irq_stat_q};
            end else if (addr == `REG_IRQ_MASK) begin
                rdata <= {27'h0000000, irq_mask_q};
            end else if (ch_hit) begin
                case (addr[3:0])
                    `REG_CH_CFG:     rdata <= {27'h0, sup_en_q[ch_sel], 1'b0, range_q[ch_sel]};
                    `REG_CH_LOW_OFF: rdata <= {{14{lo_off_q[ch_sel][17]}}, lo_off_q[ch_sel]};
                    `REG_CH_UP_OFF:  rdata <= {14'h0000, up_off_q[ch_sel]};
                    `REG_CH_ALIGN:   rdata <= {{16{align_q[ch_sel][15]}}, align_q[ch_sel]};
                    default:         rdata <= 32'h00000000;
                endcase
            end else if (meas_hit) begin
                rdata <= {{16{meas_q[addr[3:2]][15]}}, meas_q[addr[3:2]]};
            end else if (flag_hit) begin
                rdata <= {26'h0, channel_fault_flag[addr[3:2]], overflow_indicator[addr[3:2]],
                          underflow_indicator[addr[3:2]], range_fault_flag[addr[3:2]],
                          upper_tolerance_flag[addr[3:2]], lower_tolerance_flag[addr[3:2]]};
            end
        end
    end

    // ================================================================
    // Checks
    logic [19:0] gap_q;
    logic [2:0]  prev_chan_q;
    logic        evt_chg_q;

    // Period under test is void if control was written since the last tick
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            evt_chg_q <= 1'b0;
        end else if (wr_ctrl) begin
            evt_chg_q <= 1'b1;
        end else if (tick) begin
            evt_chg_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !scan_en_q || tick) begin
            gap_q <= 20'h00000;
        end else begin
            gap_q <= gap_q + 20'h00001;
        end
        if (sys_rst) begin
            prev_chan_q <= 3'h0;
        end else if (conv_start) begin
            prev_chan_q <= conv_chan;
        end
    end

    a_period_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tick && !evt_chg_q && $stable(evt_en_q) && $past(tick, 1) == 1'b0 && gap_q != 20'h0
        |-> gap_q == period_cyc - 20'h00001)
        else $error("Scan period length wrong");
    a_order_ascending: assert property (@(posedge ref_clk) disable iff (sys_rst)
        conv_start && conv_chan != 3'h0 |-> conv_chan == prev_chan_q + 3'h1)
        else $error("Channels out of order");
    a_first_chan: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == ST_IDLE && tick |=> ##1 conv_start && conv_chan == 3'h0)
        else $error("Scan did not start at channel 0");
    a_lower_tol: assert property (@(posedge ref_clk) disable iff (sys_rst)
        res_valid |=> lower_tolerance_flag[$past(res_ch_q)] == $past(res.lo_tol))
        else $error("Lower tolerance flag not updated");
    a_upper_tol: assert property (@(posedge ref_clk) disable iff (sys_rst)
        res_valid |=> upper_tolerance_flag[$past(res_ch_q)] == $past(res.up_tol))
        else $error("Upper tolerance flag not updated");
    a_status_refresh: assert property (@(posedge ref_clk) disable iff (sys_rst)
        req_valid_q |=> res_valid ##1 range_fault_flag[res_ch_q] == $past(res.fault))
        else $error("Status not refreshed after conversion");
    a_offset_limit: assert property (@(posedge ref_clk) disable iff (sys_rst)
        lo_off_q[0] <= 18'sh0 && lo_off_q[0] >= -18'sd2500 &&
        up_off_q[0] >= 18'sh0 && up_off_q[0] <= 18'sd2500)
        else $error("Threshold offset outside limits");
    a_selfcal_ref: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == ST_WAIT && conv_done && chan_q == `REF_CHAN
        |=> selfcal_q == `REF_EXPECT - 18'(signed'($past(conv_data))))
        else $error("Self calibration not taken from reference");
    a_irq_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ##1 irq == $past(|(irq_stat_q & irq_mask_q)))
        else $error("Interrupt level mismatch");
endmodule : range_monitor

// ==== adc_model.sv ====
// Converter model answering each conversion start after a set latency
`timescale 1ns/1ns
module adc_model (
    input  wire logic             ref_clk,
    input  wire logic             conv_start,
    input  wire logic [2:0]       conv_chan,
    input  wire logic [3:0][15:0] vals,
    input  wire logic [3:0]       lat,
    output logic                  conv_done,
    output logic      [15:0]      conv_data
);
    logic [15:0] last;
    initial begin
        conv_done = 1'b0;
        conv_data = 16'h0000;
        last = 16'h0000;
        forever begin
            @(posedge ref_clk);
            conv_done <= 1'b0;
            conv_data <= ~last;
            if (conv_start) begin
                repeat (lat) @(posedge ref_clk);
                last = (conv_chan == 3'h4) ? 16'h1388 : vals[conv_chan[1:0]];
                conv_done <= 1'b1;
                conv_data <= last;
            end
        end
    end
endmodule : adc_model

// ==== range_monitor_tb.sv ====
// Self-checking bench for the range monitor
`timescale 1ns/1ns
module range_monitor_tb;
    logic             ref_clk, sys_rst, wr_stb, rd_stb, conv_start, conv_done, irq;
    logic             rd_pend, per_on;
    logic [7:0]       addr;
    logic [31:0]      wdata, rdata;
    logic [2:0]       conv_chan, nxt;
    logic [15:0]      conv_data;
    logic [3:0][15:0] vals;
    logic [3:0]       lo_f, up_f, rf_f, un_f, ov_f, cf_f, ev, lat;
    logic [37:0]      e;
    logic [31:0]      expq[$];
    int               miscompares, compares, cyc, last_st, per_exp, lo[4], vv[4], mn[4];
    int               tv[5] = '{-200, 10400, -10600, 11600, -11700};

    range_monitor #(.BASE_CYC(20'd100), .EXTRA_CYC(20'd15)) i_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .conv_start(conv_start),
        .conv_chan(conv_chan), .conv_done(conv_done), .conv_data(conv_data),
        .lower_tolerance_flag(lo_f), .upper_tolerance_flag(up_f),
        .range_fault_flag(rf_f), .underflow_indicator(un_f),
        .overflow_indicator(ov_f), .channel_fault_flag(cf_f), .irq(irq));
    adc_model i_adc (.ref_clk(ref_clk), .conv_start(conv_start), .conv_chan(conv_chan),
        .vals(vals), .lat(lat), .conv_done(conv_done), .conv_data(conv_data));

    // ====================================================================
    // Helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr_stb <= 1'b1;
        addr   <= a;
        wdata  <= d;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        expq.push_back(x);
        @(posedge ref_clk);
        rd_stb <= 1'b1;
        addr   <= a;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
    endtask : rd
    task automatic scan();
        int n;
        n = 0;
        wr(8'h08, 32'h1f);
        repeat (3) @(posedge ref_clk);
        while (irq !== 1'b1 && n < 1000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 1000) miscompares++;
    endtask : scan
    function automatic logic [37:0] exp_of(int x, int l, int m);
        logic [5:0] f;
        f[0] = (x < m) && (x >= l);
        f[1] = (x > 10000) && (x <= 11250);
        f[3] = x < l;
        f[4] = x > 11250;
        f[2] = f[3] | f[4];
        f[5] = f[2];
        return {f, 32'(f[3] ? l : (f[4] ? 11250 : x))};
    endfunction : exp_of

    // ====================================================================
    // Clock and watcher
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (rd_pend) chk(rdata, expq.pop_front());
        rd_pend <= rd_stb;
        if (conv_start) begin
            chk(32'(conv_chan), 32'(nxt));
            nxt <= (nxt == 3'h4) ? 3'h0 : nxt + 3'h1;
            if (conv_chan == 3'h0 && per_on) chk(cyc - last_st, per_exp);
            if (conv_chan == 3'h0) last_st <= cyc;
        end
        if (cyc == 8000) miscompares++;
        if (cyc == 8000) close_out();
    end

    // ====================================================================
    // Main sequence
    initial begin
        {sys_rst, rd_pend} = 2'b10;
        {wr_stb, rd_stb, per_on, addr, wdata, vals, lat, nxt} = '0;
        {cyc, last_st, compares, miscompares} = '0;
        void'($urandom(39));
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(8'h80, 32'h0);
        wr(8'h0c, 32'h10);
        for (int c = 0; c < 4; c++) begin
            wr(8'(8'h10 + 16 * c), 32'h10);
            lo[c] = -11250;
            mn[c] = -10000;
        end
        for (int t = 0; t < 4; t++) begin
            if (t == 2) begin
                wr(8'h20, 32'h11);
                lo[1] = -1250;
                mn[1] = 0;
            end
            if (t == 3) wr(8'h14, 32'hfffff448);
            if (t == 3) lo[0] = -12500;
            ev = 4'($urandom);
            lat <= 4'($urandom);
            per_on <= 1'b0;
            per_exp = 100 + 15 * $countones(ev);
            for (int c = 0; c < 4; c++) begin
                vv[c] = (t == 3 && c == 0) ? -12000 : tv[(c + t) % 5] + int'($urandom % 50);
                vals[c] <= 16'(vv[c]);
            end
            wr(8'h00, {24'h0, ev, 4'h1});
            scan();
            scan();
            per_on <= 1'b1;
            scan();
            scan();
            for (int c = 0; c < 4; c++) begin
                e = exp_of(vv[c], lo[c], mn[c]);
                rd(8'(8'h50 + 4 * c), e[31:0]);
                rd(8'(8'h60 + 4 * c), {26'h0, e[37:32]});
                chk({cf_f[c], ov_f[c], un_f[c], rf_f[c], up_f[c], lo_f[c]}, e[37:32]);
            end
            rd(8'h04, 32'h0);
            $display("round %0d done", t);
        end
        wr(8'h0c, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk(32'(irq), 32'h0);
        close_out();
    end
endmodule : range_monitor_tb
